// ==== inc/rppj_pkg.sv ====
package rppj_pkg;
    // timer figures and the collision limit; values are plain defaults
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned LONG_RX_US      = 100;
    localparam int unsigned NO_COLL_US      = 20;
    localparam int unsigned LONG_RX_CYC     = (LONG_RX_US * (CLK_HZ / 1_000_000));
    localparam int unsigned NO_COLL_CYC     = (NO_COLL_US * (CLK_HZ / 1_000_000));
    localparam int unsigned CCNT_W          = 8;
    localparam int unsigned TMR_W           = 24;
    localparam logic [7:0]  CCNT_LIMIT_DEF  = 8'h3c;
    localparam logic [7:0]  CCNT_RST        = 8'h00;
    localparam logic [23:0] TMR_RST         = 24'h000000;
    localparam int unsigned MSG_W           = 8;

    typedef enum logic [1:0] {PART_IDLE, PART_HELD} rppj_part_e;

    typedef struct packed {
        logic             valid;
        logic [MSG_W-1:0] data;
    } rppj_msg_s;

    // port activity as seen at the physical layer
    typedef struct packed {
        logic rxActive;
        logic txActive;
        logic collision;
    } rppj_act_s;
endpackage : rppj_pkg

// ==== design/rppj_sync.sv ====
`timescale 1ns/10ps
module rppj_sync
    import rppj_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire rppj_act_s actIn,
    output      rppj_act_s actOut
);
    typedef struct packed {
        rppj_act_s stage1;
        rppj_act_s stage2;
    } rppj_sync_s;

    rppj_sync_s state_r;
    rppj_sync_s state_nxt;

    always_comb
    begin
        state_nxt        = state_r;
        state_nxt.stage1 = actIn;
        state_nxt.stage2 = state_r.stage1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign actOut = state_r.stage2;
endmodule : rppj_sync

// ==== design/rppj_port_guard.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - port partitions off its own receive data
// - partition when collision count reaches limit
// - partition on long reception with collision
// - count each transmission that collides
// - clear count on clean transmit or receive
// - partitioned port forwards no input messages
// - partitioned port still transmits output messages
// - partitioned port keeps watching segment activity
// - leave partition on reset or long clean activity
// - port cuts off excessive reception itself
// - jabber when one reception exceeds long timer
// - jabber blocks input messages to core
// - jabber blocks output messages from core
// - leave jabber on reset or carrier loss
module rppj_port_guard
    import rppj_pkg::*;
#(
    parameter int unsigned LONG_RX_CYCLES = LONG_RX_CYC,
    parameter int unsigned NO_COLL_CYCLES = NO_COLL_CYC,
    parameter logic [7:0]  COLL_LIMIT     = CCNT_LIMIT_DEF
)
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire rppj_act_s phyAct,
    input  wire rppj_msg_s rxMsg,
    input  wire rppj_msg_s coreMsg,
    output      rppj_msg_s toCoreMsg,
    output      rppj_msg_s toPhyMsg,
    output      logic      partitioned,
    output      logic      rxJabber
);
    typedef struct packed {
        rppj_part_e        part;
        logic              partFlag;
        logic              jabber;
        logic [CCNT_W-1:0] collCount;
        logic [TMR_W-1:0]  rxTimer;
        logic [TMR_W-1:0]  cleanTimer;
        logic              rxColl;
        logic              txColl;
        rppj_act_s         actPrev;
        rppj_msg_s         toCore;
        rppj_msg_s         toPhy;
    } rppj_guard_s;

    localparam logic [TMR_W-1:0] LONG_RX_LIM = TMR_W'(LONG_RX_CYCLES);
    localparam logic [TMR_W-1:0] NO_COLL_LIM = TMR_W'(NO_COLL_CYCLES);

    rppj_guard_s state_r;
    rppj_guard_s state_nxt;
    rppj_act_s   act;
    logic        rxEnd;
    logic        txEnd;
    logic        anyAct;

    // activity pins come from the physical layer, outside this clock
    rppj_sync u_sync
    (
        .clk    (clk),
        .rst    (rst),
        .actIn  (phyAct),
        .actOut (act)
    );

    assign rxEnd  = state_r.actPrev.rxActive && !act.rxActive;
    assign txEnd  = state_r.actPrev.txActive && !act.txActive;
    assign anyAct = act.rxActive || act.txActive;

    always_comb
    begin
        state_nxt         = state_r;
        state_nxt.actPrev = act;

        // collision seen during the current receive or transmit event
        if (act.rxActive)
        begin
            state_nxt.rxColl = state_r.rxColl || act.collision;
        end
        else
        begin
            state_nxt.rxColl = 1'b0;
        end
        if (act.txActive)
        begin
            state_nxt.txColl = state_r.txColl || act.collision;
        end
        else
        begin
            state_nxt.txColl = 1'b0;
        end

        // long-receive timer, held at its limit rather than wrapping
        if (!act.rxActive)
        begin
            state_nxt.rxTimer = TMR_RST;
        end
        else if (state_r.rxTimer != LONG_RX_LIM)
        begin
            state_nxt.rxTimer = state_r.rxTimer + 1'b1;
        end
        else
        begin
            state_nxt.rxTimer = LONG_RX_LIM;
        end

        // clean-activity timer: watched in every state
        if (!anyAct || act.collision)
        begin
            state_nxt.cleanTimer = TMR_RST;
        end
        else if (state_r.cleanTimer != NO_COLL_LIM)
        begin
            state_nxt.cleanTimer = state_r.cleanTimer + 1'b1;
        end
        else
        begin
            state_nxt.cleanTimer = NO_COLL_LIM;
        end

        // counter saturates so a long collision storm cannot wrap it
        if (txEnd && state_r.txColl)
        begin
            if (state_r.collCount != {CCNT_W{1'b1}})
            begin
                state_nxt.collCount = state_r.collCount + 1'b1;
            end
            else
            begin
                state_nxt.collCount = state_r.collCount;
            end
        end
        else if ((txEnd && !state_r.txColl) || (rxEnd && !state_r.rxColl))
        begin
            state_nxt.collCount = CCNT_RST;
        end

        unique case (state_r.part)
            PART_IDLE:
            begin
                if (state_r.collCount >= COLL_LIMIT)
                begin
                    state_nxt.part = PART_HELD;
                end
                else if (act.rxActive && state_r.rxColl
                         && state_r.rxTimer == LONG_RX_LIM)
                begin
                    state_nxt.part = PART_HELD;
                end
            end
            PART_HELD:
            begin
                // count restarts so the port is not re-partitioned at once
                if (state_r.cleanTimer == NO_COLL_LIM)
                begin
                    state_nxt.part      = PART_IDLE;
                    state_nxt.collCount = CCNT_RST;
                end
            end
            // unused codes of the state field fall back to the open state
            default:
            begin
                state_nxt.part = PART_IDLE;
            end
        endcase

        // own flop so the status pin carries no decode after the register
        state_nxt.partFlag = (state_nxt.part == PART_HELD);

        if (!act.rxActive)
        begin
            state_nxt.jabber = 1'b0;
        end
        else if (state_r.rxTimer == LONG_RX_LIM)
        begin
            state_nxt.jabber = 1'b1;
        end
        else
        begin
            state_nxt.jabber = state_r.jabber;
        end

        // message gating; one cycle of latency on both paths
        if (state_r.part == PART_HELD || state_r.jabber)
        begin
            state_nxt.toCore = '0;
        end
        else
        begin
            state_nxt.toCore = rxMsg;
        end
        if (state_r.jabber)
        begin
            state_nxt.toPhy = '0;
        end
        else
        begin
            state_nxt.toPhy = coreMsg;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign toCoreMsg   = state_r.toCore;
    assign toPhyMsg    = state_r.toPhy;
    assign partitioned = state_r.partFlag;
    assign rxJabber    = state_r.jabber;
endmodule : rppj_port_guard

// ==== testbench/rppj_guard_monitor.sv ====
`timescale 1ns/10ps
module rppj_guard_monitor
    import rppj_pkg::*;
#(parameter int unsigned LONG_RX_CYCLES = 20)
(
    input wire logic      clk,
    input wire logic      rst,
    input wire rppj_act_s phyAct,
    input wire rppj_msg_s coreMsg,
    input wire rppj_msg_s toCoreMsg,
    input wire rppj_msg_s toPhyMsg,
    input wire logic      partitioned,
    input wire logic      rxJabber
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_gc; partitioned || rxJabber |=> toCoreMsg == '0; endproperty
    a_gc: assert property (p_gc) else $error("core gate");
    property p_pp; !rxJabber |=> toPhyMsg == $past(coreMsg); endproperty
    a_pp: assert property (p_pp) else $error("phy pass");
    property p_bp; rxJabber |=> toPhyMsg == '0; endproperty
    a_bp: assert property (p_bp) else $error("phy gate");
    property p_jx; $fell(phyAct.rxActive) |-> ##3 !rxJabber; endproperty
    a_jx: assert property (p_jx) else $error("jab exit");
    property p_jr; $rose(rxJabber) |-> $past(phyAct.rxActive, LONG_RX_CYCLES + 3); endproperty
    a_jr: assert property (p_jr) else $error("jab early");
    property p_jh; phyAct.rxActive [*3] ##0 rxJabber |=> rxJabber; endproperty
    a_jh: assert property (p_jh) else $error("jab drop");
    property p_jc; $rose(rxJabber) && $past(phyAct.collision, 6) |-> partitioned; endproperty
    a_jc: assert property (p_jc) else $error("coll part");
    // idle clears the clean timer, so an idle port cannot leave partition
    property p_pi; (partitioned && !phyAct.rxActive && !phyAct.txActive) [*4] |=> partitioned;
    endproperty
    a_pi: assert property (p_pi) else $error("part drop");
    c_part: cover property ($rose(partitioned));
    c_jab: cover property ($rose(rxJabber));
    c_exit: cover property ($fell(partitioned));
endmodule : rppj_guard_monitor
bind rppj_port_guard rppj_guard_monitor #(.LONG_RX_CYCLES(LONG_RX_CYCLES)) i_mon (.*);

// ==== testbench/rppj_phy_model.sv ====
`timescale 1ns/10ps
module rppj_phy_model
    import rppj_pkg::*;
(
    input  wire logic [2:0] cmd,
    input  wire logic       clk,
    output      rppj_act_s  phyAct,
    output      rppj_msg_s  rxMsg,
    output      rppj_msg_s  coreMsg
);
    logic [7:0] seq = 8'h00;
    initial {phyAct, rxMsg, coreMsg} = '0;
    always @(negedge clk)
    begin
        seq     <= seq + 8'h01;
        phyAct  <= cmd;
        rxMsg   <= {cmd[2], seq};
        coreMsg <= {1'b1, ~seq};
    end
endmodule : rppj_phy_model

// ==== testbench/rppj_port_guard_tb.sv ====
`timescale 1ns/10ps
module rppj_port_guard_tb import rppj_pkg::*;;
    localparam int unsigned LRX = 20, NCL = 10;
    logic       clk = 1'b0, rst = 1'b1, partitioned, rxJabber;
    logic [2:0] cmd = 3'h0;
    int         fail_count = 0, checks = 0;
    rppj_act_s  phyAct;
    rppj_msg_s  rxMsg, coreMsg, toCoreMsg, toPhyMsg;
    always #10 clk = ~clk;
    rppj_phy_model i_phy (.*);
    rppj_port_guard #(.LONG_RX_CYCLES(LRX), .NO_COLL_CYCLES(NCL), .COLL_LIMIT(8'h04)) i_dut (.*);
    task chk(input string nm, input logic [17:0] s, input logic [17:0] e);
        checks++;
        fail_count += int'(s !== e);
        if (s !== e)
            $display("mismatch %s exp %h seen %h", nm, e, s);
    endtask : chk
    // idle of 0 lets the caller look while the event is still on
    task ev(input logic [2:0] c, input int n, input int idle);
        @(negedge clk);
        cmd <= c;
        repeat (n) @(negedge clk);
        cmd <= 3'h0;
        repeat (idle) @(negedge clk);
    endtask : ev
    task t_jab();
        ev(3'h4, LRX + 8, 0);
        chk("flags", {rxJabber, partitioned}, 18'h2);
        chk("msgs", {toPhyMsg, toCoreMsg}, 18'h0);
        repeat (6) @(negedge clk);
        chk("jab", rxJabber, 18'h0);
    endtask : t_jab
    task t_cnt();
        repeat (3) ev(3'h3, 4, 8);
        ev(3'h4, 4, 4);
        repeat (3) ev(3'h3, 4, 8);
        chk("part", partitioned, 18'h0);
        ev(3'h3, 4, 8);
        chk("part", partitioned, 18'h1);
        chk("phy", toPhyMsg.valid, 18'h1);
        chk("core", toCoreMsg, 18'h0);
        ev(3'h2, NCL + 8, 4);
        chk("part", partitioned, 18'h0);
    endtask : t_cnt
    task t_jc();
        ev(3'h5, LRX + 8, 6);
        chk("flags", {rxJabber, partitioned}, 18'h1);
        chk("phy", toPhyMsg.valid, 18'h1);
        chk("core", toCoreMsg, 18'h0);
    endtask : t_jc
    task stop_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (10) @(negedge clk);
        rst <= 1'b0;
        chk("flags", {rxJabber, partitioned}, 18'h0);
        t_jab();
        t_cnt();
        t_jc();
        stop_test();
    end
endmodule : rppj_port_guard_tb
